/* File: rtl/fsp_flash_ctrl.sv */
// flash self-program controller: axi4-lite register slave, unlock key,
// 32 write latches, row erase/program sequencer with stall timer.
// assumes flash array returns read data the cycle after cmd.rd.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fsp_consts.svh"

module fsp_flash_ctrl #(
   parameter int unsigned OP_CYCLES = `FSP_OP_TIME_NS / `FSP_CLK_PERIOD_NS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire fsp_pkg::fsp_cfg_t cfg,
   input wire logic [13:0] flash_rdata,
   output fsp_pkg::fsp_flash_cmd_t flash_cmd,
   output logic cpu_stall,
   input wire logic ext_req,
   input wire logic ext_bulk_erase,
   output logic ext_grant
);
   import fsp_pkg::*;

   // ************************************
   // state
   // ************************************
   fsp_state_t state_r;
   fsp_flash_cmd_t cmd_r;
   logic [7:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic w_lane0_r;
   logic aw_ok_r;
   logic w_ok_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [14:0] addr_r;
   logic [13:0] data_r;
   logic [1:0] key_r;
   logic permit_r;
   logic abort_r;
   logic latch_only_r;
   logic erase_sel_r;
   logic rd_bit_r;
   logic wr_bit_r;
   logic op_erase_r;
   logic stall_r;
   logic in_reset_r;
   logic grant_r;
   logic [4:0] idx_r;
   logic [31:0] timer_r;
   logic [13:0] latch_r [`FSP_ROW_WORDS];

   logic do_wr;
   logic ctl_wr;
   logic rd_go;
   logic wr_go;
   logic wp_hit;
   logic op_done;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic aw_ok_hit;

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign flash_cmd = cmd_r;
   assign cpu_stall = stall_r;
   assign ext_grant = grant_r;

   // ************************************
   // decode
   // ************************************
   assign do_wr = aw_ok_r & w_ok_r & ~bvalid_r;
   assign aw_ok_hit = (aw_addr_r == `FSP_OFF_ADDR_LOW) | (aw_addr_r == `FSP_OFF_ADDR_HIGH) |
                      (aw_addr_r == `FSP_OFF_DATA_LOW) | (aw_addr_r == `FSP_OFF_DATA_HIGH) |
                      (aw_addr_r == `FSP_OFF_CTRL) | (aw_addr_r == `FSP_OFF_UNLOCK);
   assign ctl_wr = do_wr & w_lane0_r & (aw_addr_r == `FSP_OFF_CTRL);
   // busy sequencer swallows new starts; read wins over write in one access
   assign rd_go = ctl_wr & w_data_r[`FSP_CTL_RD] & (state_r == FSP_ST_IDLE);
   assign wr_go = ctl_wr & w_data_r[`FSP_CTL_WR] & ~w_data_r[`FSP_CTL_RD] &
                  (state_r == FSP_ST_IDLE) & permit_r & (key_r == 2'd2);
   assign op_done = (state_r == FSP_ST_WAIT) & (timer_r == 32'h0000_0000);

   always_comb begin
      case (cfg.self_write_protect_field)
         2'b11: wp_hit = 1'b0;
         2'b10: wp_hit = addr_r < `FSP_WP_LIMIT_LOW;
         2'b01: wp_hit = addr_r < `FSP_WP_LIMIT_HALF;
         default: wp_hit = 1'b1;
      endcase
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (araddr)
         `FSP_OFF_ADDR_LOW: rd_mux[7:0] = addr_r[7:0];
         `FSP_OFF_ADDR_HIGH: rd_mux[6:0] = addr_r[14:8];
         `FSP_OFF_DATA_LOW: rd_mux[7:0] = data_r[7:0];
         `FSP_OFF_DATA_HIGH: rd_mux[5:0] = data_r[13:8];
         `FSP_OFF_CTRL: begin
            rd_mux[`FSP_CTL_RD] = rd_bit_r;
            rd_mux[`FSP_CTL_WR] = wr_bit_r;
            rd_mux[`FSP_CTL_PERMIT] = permit_r;
            rd_mux[`FSP_CTL_ABORT] = abort_r;
            rd_mux[`FSP_CTL_LATCH_ONLY] = latch_only_r;
            rd_mux[`FSP_CTL_ERASE_SEL] = erase_sel_r;
         end
         `FSP_OFF_UNLOCK: rd_mux = 32'h0000_0000;
         default: rd_hit = 1'b0;
      endcase
   end

   // ************************************
   // axi4-lite handshake
   // ************************************
   // one write and one read in flight; ready returns after the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `FSP_RESP_OKAY;
         aw_addr_r <= 8'h00;
         w_data_r <= 8'h00;
         w_lane0_r <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready_r) begin
            aw_addr_r <= awaddr;
            aw_ok_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (wvalid && wready_r) begin
            w_data_r <= wdata[7:0];
            w_lane0_r <= wstrb[0];
            w_ok_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (do_wr) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= aw_ok_hit ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
         end
         if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `FSP_RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
         end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ************************************
   // address, data and key registers
   // ************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_r <= 15'h0000;
      end else if (ce && do_wr && w_lane0_r) begin
         if (aw_addr_r == `FSP_OFF_ADDR_LOW) begin
            addr_r[7:0] <= w_data_r;
         end else if (aw_addr_r == `FSP_OFF_ADDR_HIGH) begin
            addr_r[14:8] <= w_data_r[6:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_r <= 14'h0000;
      end else if (ce) begin
         if (state_r == FSP_ST_RDCAP) begin
            data_r <= flash_rdata;
         end else if (do_wr && w_lane0_r && aw_addr_r == `FSP_OFF_DATA_LOW) begin
            data_r[7:0] <= w_data_r;
         end else if (do_wr && w_lane0_r && aw_addr_r == `FSP_OFF_DATA_HIGH) begin
            data_r[13:8] <= w_data_r[5:0];
         end
      end
   end

   // any write other than the next key step breaks the sequence
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_r <= 2'd0;
      end else if (ce && do_wr) begin
         if (w_lane0_r && aw_addr_r == `FSP_OFF_UNLOCK && w_data_r == `FSP_KEY_FIRST) begin
            key_r <= 2'd1;
         end else if (w_lane0_r && aw_addr_r == `FSP_OFF_UNLOCK &&
                      w_data_r == `FSP_KEY_SECOND && key_r == 2'd1) begin
            key_r <= 2'd2;
         end else begin
            key_r <= 2'd0;
         end
      end
   end

   // ************************************
   // control bits
   // ************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         permit_r <= 1'b0;
         latch_only_r <= 1'b0;
         erase_sel_r <= 1'b0;
      end else if (ce && ctl_wr) begin
         permit_r <= w_data_r[`FSP_CTL_PERMIT];
         latch_only_r <= w_data_r[`FSP_CTL_LATCH_ONLY];
         erase_sel_r <= w_data_r[`FSP_CTL_ERASE_SEL];
      end
   end

   // abort flag sampled at the first reset edge; the if-else chain keeps it
   // defined even when the sequencer is still unknown at power-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_reset_r <= 1'b1;
         if (in_reset_r) begin
         end else if (wr_bit_r) begin
            abort_r <= 1'b1;
         end else if (abort_r) begin
            abort_r <= 1'b1;
         end else begin
            abort_r <= 1'b0;
         end
      end else if (ce) begin
         in_reset_r <= 1'b0;
         if (ctl_wr && !w_data_r[`FSP_CTL_ABORT]) begin
            abort_r <= 1'b0;
         end
      end
   end

   // ************************************
   // write latches
   // ************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < `FSP_ROW_WORDS; i++) begin
            latch_r[i] <= `FSP_LATCH_RESET;
         end
      end else if (ce) begin
         if (op_done && !op_erase_r) begin
            for (int i = 0; i < `FSP_ROW_WORDS; i++) begin
               latch_r[i] <= `FSP_LATCH_RESET;
            end
         end else if (wr_go && w_data_r[`FSP_CTL_LATCH_ONLY]) begin
            latch_r[addr_r[4:0]] <= data_r;
         end
      end
   end

   // ************************************
   // sequencer
   // ************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= FSP_ST_IDLE;
         cmd_r <= '0;
         rd_bit_r <= 1'b0;
         wr_bit_r <= 1'b0;
         op_erase_r <= 1'b0;
         stall_r <= 1'b0;
         idx_r <= 5'h00;
         timer_r <= 32'h0000_0000;
      end else if (ce) begin
         case (state_r)
            FSP_ST_IDLE: begin
               if (rd_go) begin
                  rd_bit_r <= 1'b1;
                  cmd_r.rd <= 1'b1;
                  cmd_r.addr <= addr_r;
                  state_r <= FSP_ST_READ;
               // mode bits come from the same control word that carries the start
               end else if (wr_go && !w_data_r[`FSP_CTL_LATCH_ONLY] && !wp_hit) begin
                  wr_bit_r <= 1'b1;
                  stall_r <= 1'b1;
                  op_erase_r <= w_data_r[`FSP_CTL_ERASE_SEL];
                  idx_r <= 5'h00;
                  if (w_data_r[`FSP_CTL_ERASE_SEL]) begin
                     cmd_r.erase <= 1'b1;
                     cmd_r.addr <= {addr_r[14:5], 5'h00};
                     timer_r <= OP_CYCLES - 32'd1;
                     state_r <= FSP_ST_WAIT;
                  end else begin
                     state_r <= FSP_ST_PROG;
                  end
               end
            end
            FSP_ST_READ: begin
               cmd_r.rd <= 1'b0;
               state_r <= FSP_ST_RDCAP;
            end
            FSP_ST_RDCAP: begin
               rd_bit_r <= 1'b0;
               state_r <= FSP_ST_IDLE;
            end
            FSP_ST_PROG: begin
               cmd_r.wr <= 1'b1;
               cmd_r.addr <= {addr_r[14:5], idx_r};
               cmd_r.wdata <= latch_r[idx_r];
               idx_r <= idx_r + 5'h01;
               if (idx_r == 5'h1f) begin
                  timer_r <= OP_CYCLES - 32'd1;
                  state_r <= FSP_ST_WAIT;
               end
            end
            FSP_ST_WAIT: begin
               cmd_r.wr <= 1'b0;
               cmd_r.erase <= 1'b0;
               if (timer_r == 32'h0000_0000) begin
                  wr_bit_r <= 1'b0;
                  stall_r <= 1'b0;
                  state_r <= FSP_ST_IDLE;
               end else begin
                  timer_r <= timer_r - 32'd1;
               end
            end
            default: state_r <= FSP_ST_IDLE;
         endcase
      end
   end

   // ************************************
   // external programmer gate
   // ************************************
   // bulk erase is the only external path left when code protection is on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         grant_r <= 1'b0;
      end else if (ce) begin
         grant_r <= ext_req & (cfg.code_protect_n | ext_bulk_erase);
      end
   end

   // ************************************
   // checks
   // ************************************
   property p_rd_issue;
      @(posedge aclk) disable iff (!aresetn)
      (ce && rd_go) |=> rd_bit_r && cmd_r.rd && cmd_r.addr == $past(addr_r);
   endproperty
   a_rd_issue: assert property (p_rd_issue) else $error("read start not issued");

   property p_rd_capture;
      @(posedge aclk) disable iff (!aresetn)
      (ce && state_r == FSP_ST_RDCAP) |=> !rd_bit_r && data_r == $past(flash_rdata);
   endproperty
   a_rd_capture: assert property (p_rd_capture) else $error("read word lost");

   property p_key_zero;
      @(posedge aclk) disable iff (!aresetn)
      (ce && arvalid && arready_r && araddr == `FSP_OFF_UNLOCK) |=> rvalid_r && rdata_r == 0;
   endproperty
   a_key_zero: assert property (p_key_zero) else $error("key register read not zero");

   property p_no_key;
      @(posedge aclk) disable iff (!aresetn)
      (ce && ctl_wr && w_data_r[`FSP_CTL_WR] && key_r != 2'd2 && state_r == FSP_ST_IDLE)
         |=> !wr_bit_r && !stall_r;
   endproperty
   a_no_key: assert property (p_no_key) else $error("write started without key");

   property p_permit;
      @(posedge aclk) disable iff (!aresetn)
      $rose(wr_bit_r) |-> $past(permit_r) && $past(key_r) == 2'd2;
   endproperty
   a_permit: assert property (p_permit) else $error("write without permit");

   property p_latch_clear;
      @(posedge aclk) disable iff (!aresetn)
      (ce && op_done && !op_erase_r) |=> latch_r[0] == `FSP_LATCH_RESET &&
         latch_r[`FSP_ROW_WORDS - 1] == `FSP_LATCH_RESET;
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latches not reset");

   property p_stall;
      @(posedge aclk) disable iff (!aresetn)
      (state_r == FSP_ST_WAIT || state_r == FSP_ST_PROG) |-> stall_r && wr_bit_r;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall during operation");

   property p_busy;
      @(posedge aclk) disable iff (!aresetn)
      (ce && state_r == FSP_ST_WAIT && timer_r > 1 && ctl_wr) |=> !rd_bit_r && stall_r;
   endproperty
   a_busy: assert property (p_busy) else $error("start taken while busy");

   property p_wp;
      @(posedge aclk) disable iff (!aresetn)
      (ce && wr_go && !w_data_r[`FSP_CTL_LATCH_ONLY] && wp_hit)
         |=> state_r == FSP_ST_IDLE && !cmd_r.erase;
   endproperty
   a_wp: assert property (p_wp) else $error("protected region changed");

   property p_code_prot;
      @(posedge aclk) disable iff (!aresetn)
      (ce && ext_req && !cfg.code_protect_n && !ext_bulk_erase) |=> !grant_r;
   endproperty
   a_code_prot: assert property (p_code_prot) else $error("protected device granted");

   property p_abort;
      @(posedge aclk) disable iff (1'b0)
      (!aresetn && !in_reset_r && wr_bit_r) |=> abort_r;
   endproperty
   a_abort: assert property (p_abort) else $error("abort flag not set");

endmodule // fsp_flash_ctrl

/* File: rtl/fsp_consts.svh */
// offsets, field positions, reset values and timing counts of the flash
// self-program controller; included by the package user, no logic here.
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH

// ************************************
// register byte offsets
// ************************************
`define FSP_OFF_ADDR_LOW 8'h00
`define FSP_OFF_ADDR_HIGH 8'h04
`define FSP_OFF_DATA_LOW 8'h08
`define FSP_OFF_DATA_HIGH 8'h0c
`define FSP_OFF_CTRL 8'h10
`define FSP_OFF_UNLOCK 8'h14

// ************************************
// control register fields
// ************************************
`define FSP_CTL_RD 0
`define FSP_CTL_WR 1
`define FSP_CTL_PERMIT 2
`define FSP_CTL_ABORT 3
`define FSP_CTL_LATCH_ONLY 4
`define FSP_CTL_ERASE_SEL 5

// ************************************
// values and timing
// ************************************
`define FSP_KEY_FIRST 8'h55
`define FSP_KEY_SECOND 8'haa
`define FSP_LATCH_RESET 14'h3fff
`define FSP_ROW_WORDS 32
`define FSP_WP_LIMIT_LOW 15'h0200
`define FSP_WP_LIMIT_HALF 15'h4000
`define FSP_OP_TIME_NS 2000000
`define FSP_CLK_PERIOD_NS 8
`define FSP_RESP_OKAY 2'b00
`define FSP_RESP_SLVERR 2'b10

`endif

/* File: rtl/fsp_pkg.sv */
// types shared by the flash self-program controller and its users.
// assumes nothing of its surroundings.
package fsp_pkg;

   // ************************************
   // sequencer states
   // ************************************
   typedef enum logic [4:0] {
      FSP_ST_IDLE = 5'b00001,
      FSP_ST_READ = 5'b00010,
      FSP_ST_RDCAP = 5'b00100,
      FSP_ST_PROG = 5'b01000,
      FSP_ST_WAIT = 5'b10000
   } fsp_state_t;

   // ************************************
   // carriers
   // ************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic erase;
      logic [14:0] addr;
      logic [13:0] wdata;
   } fsp_flash_cmd_t;

   typedef struct packed {
      logic code_protect_n;
      logic [1:0] self_write_protect_field;
   } fsp_cfg_t;

endpackage

/* File: sim/test_flash_self_program_control.sv */
// self-checking bench for the flash self-program controller: axi4-lite master
// tasks, a flash array stand-in, and one task per scenario.
// assumes the design files under rtl/ are compiled first.
`timescale 1ns/1ps
`include "fsp_consts.svh"

module test_flash_self_program_control;
   import fsp_pkg::*;

   // ************************************
   // settings and signals
   // ************************************
   // short stall time keeps the run small; every stall-count expectation uses OP
   localparam int OP = 20;
   localparam int LIMIT = 20000;
   localparam logic [31:0] B_RD = 32'h1 << `FSP_CTL_RD;
   localparam logic [31:0] B_WR = 32'h1 << `FSP_CTL_WR;
   localparam logic [31:0] B_P = 32'h1 << `FSP_CTL_PERMIT;
   localparam logic [31:0] B_AB = 32'h1 << `FSP_CTL_ABORT;
   localparam logic [31:0] B_LT = 32'h1 << `FSP_CTL_LATCH_ONLY;
   localparam logic [31:0] B_ER = 32'h1 << `FSP_CTL_ERASE_SEL;

   logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, cpu_stall, ext_req, ext_bulk_erase, ext_grant;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic [13:0] flash_rdata, wr_d3;
   logic [14:0] er_addr;
   fsp_cfg_t cfg;
   fsp_flash_cmd_t flash_cmd;
   int n_errors, cmp_count, cycles, wr_cnt, wr_bad, er_cnt, rd_cnt, stall_cnt;

   fsp_flash_ctrl #(.OP_CYCLES(OP)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .cfg(cfg), .flash_rdata(flash_rdata),
      .flash_cmd(flash_cmd), .cpu_stall(cpu_stall), .ext_req(ext_req),
      .ext_bulk_erase(ext_bulk_erase), .ext_grant(ext_grant));

   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // ************************************
   // flash stand-in, monitor and timeout
   // ************************************
   // read data is a function of the address; between reads it toggles
   always @(posedge aclk) begin
      flash_rdata <= flash_cmd.rd ? (flash_cmd.addr[13:0] ^ 14'h1234) : ~flash_rdata;
      if (flash_cmd.wr) begin
         wr_cnt++;
         if (flash_cmd.addr[14:5] !== 10'h022)
            wr_bad++;
         if (flash_cmd.addr[4:0] == 5'd3)
            wr_d3 = flash_cmd.wdata;
         else if (flash_cmd.wdata !== `FSP_LATCH_RESET)
            wr_bad++;
      end
      if (flash_cmd.erase) begin
         er_cnt++;
         er_addr = flash_cmd.addr;
      end
      if (flash_cmd.rd)
         rd_cnt++;
      if (cpu_stall)
         stall_cnt++;
      cycles++;
      if (cycles == LIMIT) begin
         n_errors++;
         end_of_test();
      end
   end

   // ************************************
   // bus tasks and helpers
   // ************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      begin
         aw_ok = 1'b0;
         w_ok = 1'b0;
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
               aw_ok = 1'b1;
               awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
               w_ok = 1'b1;
               wvalid <= 1'b0;
            end
         end
         do @(posedge aclk); while (!bvalid);
         resp = bresp;
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge aclk); while (!arready);
         arvalid <= 1'b0;
         do @(posedge aclk); while (!rvalid);
         d = rdata;
         resp = rresp;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         cmp_count++;
         if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
         end
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      begin
         rd(a, v);
         chk(v, exp);
      end
   endtask

   // key then control write; the key is consumed by that write
   task automatic go(input logic [31:0] c);
      begin
         wr(`FSP_OFF_UNLOCK, 32'h55);
         wr(`FSP_OFF_UNLOCK, 32'haa);
         wr(`FSP_OFF_CTRL, c);
      end
   endtask

   task automatic wait_idle;
      int i;
      begin
         for (i = 0; i < 100; i++) begin
            rd(`FSP_OFF_CTRL, v);
            if (v[1:0] === 2'b00)
               break;
         end
      end
   endtask

   task automatic set_addr(input logic [14:0] a);
      begin
         wr(`FSP_OFF_ADDR_LOW, {24'h0, a[7:0]});
         wr(`FSP_OFF_ADDR_HIGH, {25'h0, a[14:8]});
      end
   endtask

   task automatic do_reset;
      begin
         aresetn <= 1'b0;
         repeat (4) @(posedge aclk);
         aresetn <= 1'b1;
         @(posedge aclk);
      end
   endtask

   // ************************************
   // scenarios
   // ************************************
   task automatic t_regs;
      begin
         rchk(`FSP_OFF_CTRL, 32'h0);
         wr(`FSP_OFF_UNLOCK, 32'h55);
         rchk(`FSP_OFF_UNLOCK, 32'h0);
         rchk(8'h18, 32'h0);
         chk(resp, `FSP_RESP_SLVERR);
         wr(8'h18, 32'h0);
         chk(resp, `FSP_RESP_SLVERR);
         set_addr(15'h7fff);
         chk(resp, `FSP_RESP_OKAY);
         wstrb <= 4'h0;
         wr(`FSP_OFF_ADDR_LOW, 32'h11);
         wstrb <= 4'hf;
         rchk(`FSP_OFF_ADDR_HIGH, 32'h7f);
         chk(resp, `FSP_RESP_OKAY);
         rchk(`FSP_OFF_ADDR_LOW, 32'hff);
         wr(`FSP_OFF_DATA_HIGH, 32'h3f);
         wr(`FSP_OFF_DATA_LOW, 32'h5a);
         rchk(`FSP_OFF_DATA_HIGH, 32'h3f);
         rchk(`FSP_OFF_DATA_LOW, 32'h5a);
         $display("test regs done");
      end
   endtask

   task automatic t_read;
      logic [13:0] e;
      begin
         e = 14'h35bc ^ 14'h1234;
         set_addr(15'h35bc);
         rd_cnt = 0;
         wr(`FSP_OFF_CTRL, B_RD);
         wait_idle();
         chk(v, 32'h0);
         chk(rd_cnt, 1);
         rchk(`FSP_OFF_DATA_LOW, {24'h0, e[7:0]});
         rchk(`FSP_OFF_DATA_HIGH, {26'h0, e[13:8]});
         $display("test read done");
      end
   endtask

   task automatic t_program;
      begin
         wr_cnt = 0;
         wr_bad = 0;
         stall_cnt = 0;
         set_addr(15'h0443);
         wr(`FSP_OFF_DATA_HIGH, 32'h2a);
         wr(`FSP_OFF_DATA_LOW, 32'hc3);
         go(B_WR);
         wr(`FSP_OFF_CTRL, B_P);
         wr(`FSP_OFF_CTRL, B_WR | B_P);
         rchk(`FSP_OFF_CTRL, B_P);
         go(B_WR | B_P | B_LT);
         rchk(`FSP_OFF_CTRL, B_P | B_LT);
         go(B_WR | B_P);
         wait_idle();
         chk(wr_cnt, 32);
         chk(wr_d3, 14'h2ac3);
         chk(wr_bad, 0);
         chk(stall_cnt >= 32 + OP && stall_cnt <= 40 + OP, 1);
         wr(`FSP_OFF_CTRL, B_P);
         go(B_WR | B_P);
         wait_idle();
         chk(wr_d3, `FSP_LATCH_RESET);
         chk(wr_cnt, 64);
         $display("test program done");
      end
   endtask

   task automatic t_erase;
      begin
         er_cnt = 0;
         rd_cnt = 0;
         stall_cnt = 0;
         cfg <= '{code_protect_n: 1'b1, self_write_protect_field: 2'b10};
         set_addr(15'h0045);
         wr(`FSP_OFF_CTRL, B_P);
         go(B_WR | B_P | B_ER);
         wait_idle();
         chk(er_cnt, 0);
         set_addr(15'h0245);
         go(B_WR | B_P | B_ER);
         wr(`FSP_OFF_CTRL, B_RD | B_P);
         wait_idle();
         chk(er_cnt, 1);
         chk(er_addr, 15'h0240);
         chk(rd_cnt, 0);
         chk(stall_cnt >= OP && stall_cnt <= OP + 8, 1);
         $display("test erase done");
      end
   endtask

   task automatic t_abort;
      begin
         cfg <= '{code_protect_n: 1'b1, self_write_protect_field: 2'b11};
         wr(`FSP_OFF_CTRL, B_P);
         go(B_WR | B_P | B_ER);
         do_reset();
         rchk(`FSP_OFF_CTRL, B_AB);
         wr(`FSP_OFF_CTRL, 32'h0);
         rchk(`FSP_OFF_CTRL, 32'h0);
         $display("test abort done");
      end
   endtask

   task automatic t_ext;
      begin
         cfg <= '{code_protect_n: 1'b0, self_write_protect_field: 2'b11};
         ext_req <= 1'b1;
         repeat (2) @(posedge aclk);
         chk(ext_grant, 1'b0);
         ext_bulk_erase <= 1'b1;
         repeat (2) @(posedge aclk);
         chk(ext_grant, 1'b1);
         cfg <= '{code_protect_n: 1'b1, self_write_protect_field: 2'b00};
         ext_bulk_erase <= 1'b0;
         repeat (2) @(posedge aclk);
         chk(ext_grant, 1'b1);
         ext_req <= 1'b0;
         $display("test ext done");
      end
   endtask

   task automatic end_of_test;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, ext_req, ext_bulk_erase} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      flash_rdata = 14'h0;
      cfg = '{code_protect_n: 1'b1, self_write_protect_field: 2'b11};
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_read();
      t_program();
      t_erase();
      t_abort();
      t_ext();
      end_of_test();
   end
endmodule // test_flash_self_program_control
